// file: verilog/dfmc_regs.vh
// register indices, field positions, codes and reset values of the misc control bank
`ifndef DFMC_REGS_VH
`define DFMC_REGS_VH
// register indices; byte address is four times the index
`define DFMC_IDX_PORT0      14'h0080
`define DFMC_IDX_DIR1       14'h0091
`define DFMC_IDX_PORT1      14'h0090
`define DFMC_IDX_ERASE_CMD  14'h0094
`define DFMC_IDX_EE_DATA    14'h009e
`define DFMC_IDX_EE_CTL     14'h009f
`define DFMC_IDX_PORT2      14'h00a0
`define DFMC_IDX_DIR2       14'h00a1
`define DFMC_IDX_DIR0       14'h00a2
`define DFMC_IDX_MEEN       14'h00b2
`define DFMC_IDX_PAGE       14'h00b7
`define DFMC_IDX_PWR_EQN    14'h2000
`define DFMC_IDX_IRQ_EN     14'h2002
`define DFMC_IDX_MISC       14'h2005
`define DFMC_IDX_ROUTE      14'h2008
`define DFMC_IDX_DISPLAY_PIN_COUNT    14'h2020
`define DFMC_IDX_STATUS     14'h2030
`define DFMC_IDX_MASK       14'h2031
// field positions
`define DFMC_PWR_EQN_LSB    5
`define DFMC_IEN_XFER_BIT   0
`define DFMC_IEN_RTC_BIT    1
`define DFMC_MISC_SUPPLY    1
`define DFMC_MISC_DECIM     4
`define DFMC_MISC_ECK_OFF   5
`define DFMC_ROUTE_VAR      2
`define DFMC_ROUTE_WATT     3
`define DFMC_ROUTE_EE       4
`define DFMC_MEEN_BIT       1
`define DFMC_PAGE_LSB       1
`define DFMC_EE_SCL_BIT     0
`define DFMC_EE_SDA_LOW_BIT 1
`define DFMC_EE_SDA_IN_BIT  7
// pin numbers
`define DFMC_NUM_PINS       22
`define DFMC_FIRST_LCD_PIN  4
`define DFMC_PIN_SCL        4
`define DFMC_PIN_SDA        5
`define DFMC_PIN_WATT       6
`define DFMC_PIN_VAR        7
`define DFMC_LCD_MAX        5'h12
// erase codes
`define DFMC_CODE_MASS      8'haa
`define DFMC_CODE_PAGE      8'h55
// status bits
`define DFMC_ST_XFER        0
`define DFMC_ST_RTC         1
`define DFMC_ST_MASS        2
`define DFMC_ST_PAGE        3
`define DFMC_ST_W           4
// reset values
`define DFMC_RST_BYTE       8'h00
`define DFMC_RST_PINS       22'h000000
`endif

// file: verilog/dfmc_top.v
// pin data ports, pulse routing, eeprom pin mode, erase control and misc config over apb
//
// Notes on behaviour
// - port read returns pin level, display pins zero
// - port write changes only output pins
// - eeprom mode: pin4 clock, pin5 bidirectional data
// - emulator clock off blocks debug and mass erase; page erase is not blocked
// - power equation field selects engine equation
// - two enables gate transfer-busy and rtc interrupts
// - decimation bit picks 22 or 21 bits
// - code 0xaa starts mass erase when enabled
// - code 0x55 starts page erase; any code other than 0xaa and 0x55 is ignored
// - mass erase enable resets off, one enables
// - page number 0..127, rewritten before each erase
// - direction one means output, gpio pins only
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`include "dfmc_regs.vh"

module dfmc_top (
  input  wire        ref_clk_in,
  input  wire        rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [15:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire [21:0] gp_pin_in,
  output reg  [21:0] gp_pin_out,
  output reg  [21:0] gp_pin_oe_out,
  input  wire        reactive_energy_pulse_in,
  input  wire        real_energy_pulse_in,
  input  wire        transfer_busy_irq_in,
  input  wire        rtc_irq_in,
  output reg  [2:0]  power_equation_out,
  output reg         decimation_long_out,
  output reg         supply_current_reduce_out,
  output reg         emulator_clock_enable_out,
  output reg         mpu_xfer_irq_out,
  output reg         mpu_rtc_irq_out,
  output reg         mass_erase_start_out,
  output reg         page_erase_start_out,
  output reg  [6:0]  erase_page_number_out,
  output reg         irq_out
);

  // pins handed to the display driver, counted down from pin 21
  function [21:0] lcd_mask;
    input [4:0] count;
    integer     i;
    begin
      lcd_mask = `DFMC_RST_PINS;
      for (i = `DFMC_FIRST_LCD_PIN; i < `DFMC_NUM_PINS; i = i + 1) begin
        if ((i + count) >= `DFMC_NUM_PINS)
          lcd_mask[i] = 1'b1;
      end
    end
  endfunction

  // two-flop synchroniser for the pad levels
  reg [21:0] pin_meta_r;
  reg [21:0] pin_sync_r;

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pin_meta_r <= `DFMC_RST_PINS;
      pin_sync_r <= `DFMC_RST_PINS;
    end else begin
      pin_meta_r <= gp_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // stored configuration
  reg [21:0] dir_r;
  reg [21:0] odata_r;
  reg [4:0]  lcd_cnt_r;
  reg [2:0]  pwr_eqn_r;
  reg [1:0]  irq_en_r;
  reg        supply_r;
  reg        decim_r;
  reg        eck_off_r;
  reg        var_route_r;
  reg        watt_route_r;
  reg        ee_mode_r;
  reg [7:0]  ee_data_r;
  reg [1:0]  ee_ctl_r;
  reg        meen_r;
  reg [6:0]  page_r;
  reg        page_valid_r;
  reg [3:0]  status_r;
  reg [3:0]  mask_r;

  // apb decode; unaligned or unknown addresses answer with pslverr
  wire [13:0] idx     = paddr_in[15:2];
  wire        aligned = (paddr_in[1:0] == 2'b00);
  wire        setup   = psel_in & ~penable_in;
  wire        access  = psel_in & penable_in & pready_out;
  wire        wr      = access & pwrite_in & ~pslverr_out;
  wire        rd_stat = access & ~pwrite_in & ~pslverr_out & (idx == `DFMC_IDX_STATUS);
  wire [7:0]  wbyte   = pwdata_in[7:0];
  wire [21:0] lcd     = lcd_mask(lcd_cnt_r);
  wire [21:0] pin_rd  = pin_sync_r & ~lcd;
  wire        debug_en = ~eck_off_r;

  reg        hit;
  reg [7:0]  rbyte;

  // read mux and address hit
  always @* begin
    hit   = aligned;
    rbyte = `DFMC_RST_BYTE;
    case (idx)
      `DFMC_IDX_PORT0:     rbyte = pin_rd[7:0];
      `DFMC_IDX_PORT1:     rbyte = pin_rd[15:8];
      `DFMC_IDX_PORT2:     rbyte = {2'b00, pin_rd[21:16]};
      `DFMC_IDX_DIR0:      rbyte = dir_r[7:0];
      `DFMC_IDX_DIR1:      rbyte = dir_r[15:8];
      `DFMC_IDX_DIR2:      rbyte = {2'b00, dir_r[21:16]};
      `DFMC_IDX_ERASE_CMD: rbyte = `DFMC_RST_BYTE;
      `DFMC_IDX_EE_DATA:   rbyte = ee_data_r;
      `DFMC_IDX_EE_CTL: begin
        rbyte = {6'b000000, ee_ctl_r};
        rbyte[`DFMC_EE_SDA_IN_BIT] = pin_sync_r[`DFMC_PIN_SDA];
      end
      `DFMC_IDX_MEEN:      rbyte = `DFMC_RST_BYTE; // write-only
      `DFMC_IDX_PAGE:      rbyte = `DFMC_RST_BYTE; // write-only
      `DFMC_IDX_PWR_EQN:   rbyte = {pwr_eqn_r, 5'b00000};
      `DFMC_IDX_IRQ_EN:    rbyte = {6'b000000, irq_en_r};
      `DFMC_IDX_MISC: begin
        rbyte[`DFMC_MISC_SUPPLY]  = supply_r;
        rbyte[`DFMC_MISC_DECIM]   = decim_r;
        rbyte[`DFMC_MISC_ECK_OFF] = eck_off_r;
      end
      `DFMC_IDX_ROUTE: begin
        rbyte[`DFMC_ROUTE_VAR]  = var_route_r;
        rbyte[`DFMC_ROUTE_WATT] = watt_route_r;
        rbyte[`DFMC_ROUTE_EE]   = ee_mode_r;
      end
      `DFMC_IDX_DISPLAY_PIN_COUNT:   rbyte = {3'b000, lcd_cnt_r};
      `DFMC_IDX_STATUS:    rbyte = {4'h0, status_r};
      `DFMC_IDX_MASK:      rbyte = {4'h0, mask_r};
      default:             hit = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle so every bus output is a flop
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      if (setup) begin
        prdata_out  <= pwrite_in ? 32'h00000000 : {24'h000000, rbyte};
        pslverr_out <= ~hit;
      end else if (access) begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // port writes touch only pins that are gpio outputs
  wire [21:0] wr_ok = dir_r & ~lcd;
  reg  [21:0] odata_nxt;
  reg  [21:0] wr_bits;

  always @* begin
    wr_bits   = `DFMC_RST_PINS;
    odata_nxt = odata_r;
    if (wr && idx == `DFMC_IDX_PORT0)
      wr_bits = {14'h0000, wbyte};
    else if (wr && idx == `DFMC_IDX_PORT1)
      wr_bits = {6'h00, wbyte, 8'h00};
    else if (wr && idx == `DFMC_IDX_PORT2)
      wr_bits = {wbyte[5:0], 16'h0000};
    if (wr && (idx == `DFMC_IDX_PORT0 || idx == `DFMC_IDX_PORT1 || idx == `DFMC_IDX_PORT2))
      odata_nxt = (odata_r & ~(wr_ok & mask_of(idx))) | (wr_bits & wr_ok);
  end

  // which data bits a port index covers
  function [21:0] mask_of;
    input [13:0] i;
    begin
      case (i)
        `DFMC_IDX_PORT0: mask_of = 22'h0000ff;
        `DFMC_IDX_PORT1: mask_of = 22'h00ff00;
        `DFMC_IDX_PORT2: mask_of = 22'h3f0000;
        default:         mask_of = `DFMC_RST_PINS;
      endcase
    end
  endfunction

  // configuration register writes
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      dir_r        <= `DFMC_RST_PINS;
      odata_r      <= `DFMC_RST_PINS;
      lcd_cnt_r    <= 5'h00;
      pwr_eqn_r    <= 3'h0;
      irq_en_r     <= 2'h0;
      supply_r     <= 1'b0;
      decim_r      <= 1'b0;
      eck_off_r    <= 1'b0;
      var_route_r  <= 1'b0;
      watt_route_r <= 1'b0;
      ee_mode_r    <= 1'b0;
      ee_data_r    <= `DFMC_RST_BYTE;
      ee_ctl_r     <= 2'h0;
      mask_r       <= 4'h0;
    end else begin
      odata_r <= odata_nxt;
      if (wr) begin
        case (idx)
          `DFMC_IDX_DIR0:    dir_r[7:0]   <= wbyte;
          `DFMC_IDX_DIR1:    dir_r[15:8]  <= wbyte;
          `DFMC_IDX_DIR2:    dir_r[21:16] <= wbyte[5:0];
          `DFMC_IDX_DISPLAY_PIN_COUNT: lcd_cnt_r    <= wbyte[4:0];
          `DFMC_IDX_PWR_EQN: pwr_eqn_r    <= wbyte[7:`DFMC_PWR_EQN_LSB];
          `DFMC_IDX_IRQ_EN:  irq_en_r     <= wbyte[1:0];
          `DFMC_IDX_MISC: begin
            supply_r  <= wbyte[`DFMC_MISC_SUPPLY];
            decim_r   <= wbyte[`DFMC_MISC_DECIM];
            eck_off_r <= wbyte[`DFMC_MISC_ECK_OFF];
          end
          `DFMC_IDX_ROUTE: begin
            var_route_r  <= wbyte[`DFMC_ROUTE_VAR];
            watt_route_r <= wbyte[`DFMC_ROUTE_WATT];
            ee_mode_r    <= wbyte[`DFMC_ROUTE_EE];
          end
          `DFMC_IDX_EE_DATA: ee_data_r <= wbyte;
          `DFMC_IDX_EE_CTL:  ee_ctl_r  <= wbyte[1:0];
          `DFMC_IDX_MASK:    mask_r    <= wbyte[3:0];
          default: ;
        endcase
      end
    end
  end

  // erase control; page number is consumed by each page erase
  wire wr_cmd  = wr & (idx == `DFMC_IDX_ERASE_CMD);
  wire do_mass = wr_cmd & (wbyte == `DFMC_CODE_MASS) & meen_r & debug_en;
  wire do_page = wr_cmd & (wbyte == `DFMC_CODE_PAGE) & page_valid_r;

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      meen_r                <= 1'b0;
      page_r                <= 7'h00;
      page_valid_r          <= 1'b0;
      mass_erase_start_out  <= 1'b0;
      page_erase_start_out  <= 1'b0;
      erase_page_number_out <= 7'h00;
    end else begin
      // other codes fall through without any effect
      mass_erase_start_out <= do_mass;
      page_erase_start_out <= do_page;
      if (wr && idx == `DFMC_IDX_MEEN)
        meen_r <= wbyte[`DFMC_MEEN_BIT];
      if (wr && idx == `DFMC_IDX_PAGE) begin
        page_r       <= wbyte[7:`DFMC_PAGE_LSB];
        page_valid_r <= 1'b1;
      end else if (do_page) begin
        page_valid_r <= 1'b0;
      end
      if (do_page)
        erase_page_number_out <= page_r;
    end
  end

  // pin drive: gpio outputs, pulse routes, eeprom pins; display pins float unless eeprom mode claims pin 4 or 5
  reg [21:0] pout_nxt;
  reg [21:0] poe_nxt;

  always @* begin
    poe_nxt  = dir_r & ~lcd;
    pout_nxt = odata_r & poe_nxt;
    if (var_route_r && poe_nxt[`DFMC_PIN_VAR])
      pout_nxt[`DFMC_PIN_VAR] = reactive_energy_pulse_in;
    if (watt_route_r && poe_nxt[`DFMC_PIN_WATT])
      pout_nxt[`DFMC_PIN_WATT] = real_energy_pulse_in;
    if (ee_mode_r) begin
      // data line is open drain: only ever pulled low
      poe_nxt[`DFMC_PIN_SCL]  = 1'b1;
      pout_nxt[`DFMC_PIN_SCL] = ee_ctl_r[`DFMC_EE_SCL_BIT];
      poe_nxt[`DFMC_PIN_SDA]  = ee_ctl_r[`DFMC_EE_SDA_LOW_BIT];
      pout_nxt[`DFMC_PIN_SDA] = 1'b0;
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      gp_pin_out    <= `DFMC_RST_PINS;
      gp_pin_oe_out <= `DFMC_RST_PINS;
    end else begin
      gp_pin_out    <= pout_nxt;
      gp_pin_oe_out <= poe_nxt;
    end
  end

  // sticky status; clear only what the read returned so a late event survives
  wire [3:0] events = {do_page, do_mass,
                       rtc_irq_in & irq_en_r[`DFMC_IEN_RTC_BIT],
                       transfer_busy_irq_in & irq_en_r[`DFMC_IEN_XFER_BIT]};
  wire [3:0] clr    = rd_stat ? prdata_out[3:0] : 4'h0;
  wire [3:0] status_nxt = (status_r & ~clr) | events;

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      status_r                  <= 4'h0;
      irq_out                   <= 1'b0;
      mpu_xfer_irq_out          <= 1'b0;
      mpu_rtc_irq_out           <= 1'b0;
      power_equation_out        <= 3'h0;
      decimation_long_out       <= 1'b0;
      supply_current_reduce_out <= 1'b0;
      emulator_clock_enable_out <= 1'b0;
    end else begin
      status_r                  <= status_nxt;
      irq_out                   <= |(status_nxt & mask_r);
      mpu_xfer_irq_out          <= events[`DFMC_ST_XFER];
      mpu_rtc_irq_out           <= events[`DFMC_ST_RTC];
      power_equation_out        <= pwr_eqn_r;
      decimation_long_out       <= decim_r;
      supply_current_reduce_out <= supply_r;
      emulator_clock_enable_out <= debug_en;
    end
  end

endmodule

// file: verification/dfmc_top_sva.sv
// concurrent checks on bus timing, erase starts, config outputs and irq gating
`timescale 1ns/100ps
module dfmc_top_sva (
  input wire        ref_clk_in,
  input wire        rst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [15:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire        rtc_irq_in,
  input wire [2:0]  power_equation_out,
  input wire        decimation_long_out,
  input wire        emulator_clock_enable_out,
  input wire        mpu_rtc_irq_out,
  input wire        mass_erase_start_out,
  input wire        page_erase_start_out
);
  // write accepted at this edge
  wire wr_end = psel_in & penable_in & pwrite_in & pready_out;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  bus_ready_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("ready missing after setup");
  bad_addr_a: assert property (psel_in && !penable_in && paddr_in[1:0] != 2'h0 |=> pslverr_out)
    else $error("unaligned access not refused");
  mass_cause_a: assert property (mass_erase_start_out |-> $past(wr_end) &&
    $past(paddr_in) == 16'h0250 && $past(pwdata_in[7:0]) == 8'haa) else $error("stray mass start");
  mass_pulse_a: assert property (mass_erase_start_out |=> !mass_erase_start_out)
    else $error("mass start too long");
  page_cause_a: assert property (page_erase_start_out |-> $past(wr_end) &&
    $past(paddr_in) == 16'h0250 && $past(pwdata_in[7:0]) == 8'h55)
    else $error("stray page start");
  // two cycles covers a register plus an output flop
  clk_off_a: assert property (wr_end && paddr_in == 16'h8014 |-> ##2
    emulator_clock_enable_out == !$past(pwdata_in[5], 2)) else $error("clock enable wrong");
  pwr_eqn_a: assert property (wr_end && paddr_in == 16'h8000 |-> ##2
    power_equation_out == $past(pwdata_in[7:5], 2)) else $error("equation wrong");
  decim_len_a: assert property (wr_end && paddr_in == 16'h8014 |-> ##2
    decimation_long_out == $past(pwdata_in[4], 2)) else $error("decimation wrong");
  rtc_gate_a: assert property (mpu_rtc_irq_out |-> $past(rtc_irq_in))
    else $error("rtc irq without event");
  cover property (mass_erase_start_out);
  cover property (page_erase_start_out);
  cover property (mpu_rtc_irq_out);
endmodule

bind dfmc_top dfmc_top_sva chk (.*);

// file: verification/dfmc_pad_model.sv
// pad and far-side model: resolves driven pins against the external levels
`timescale 1ns/100ps
module dfmc_pad_model (
  input  wire [21:0] out_in,
  input  wire [21:0] oe_in,
  input  wire [21:0] ext_in,
  output wire [21:0] lvl_out
);
  // released pins show the far side, so serial data idles at its pull-up
  assign lvl_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule

// file: verification/dio_flash_misc_control_tb.sv
// self-checking bench for the pin, erase and config register bank
`timescale 1ns/100ps
`include "dfmc_regs.vh"
module dio_flash_misc_control_tb;
  logic        ref_clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, r;
  logic [21:0] gp_pin_in, gp_pin_out, gp_pin_oe_out, ext;
  logic        reactive_energy_pulse_in, real_energy_pulse_in, transfer_busy_irq_in;
  logic        rtc_irq_in, decimation_long_out, supply_current_reduce_out, err;
  logic        emulator_clock_enable_out, mpu_xfer_irq_out, mpu_rtc_irq_out, irq_out;
  logic        mass_erase_start_out, page_erase_start_out;
  logic [2:0]  power_equation_out;
  logic [6:0]  erase_page_number_out;
  int          num_errors, checks;
  dfmc_top uut (.*);
  dfmc_pad_model pad (.out_in(gp_pin_out), .oe_in(gp_pin_oe_out), .ext_in(ext), .lvl_out(gp_pin_in));
  // free-running 50 MHz clock
  initial begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task xfer(input logic w, input logic [13:0] i, input logic [7:0] d);
    int n;
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= {i, 2'h0};
    pwdata_in <= {24'h0, d};
    tick(1);
    penable_in <= 1'h1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      finish_test;
    end
    r = prdata_out;
    err = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    tick(1);
  endtask
  task wr(input logic [13:0] i, input logic [7:0] d);
    xfer(1'h1, i, d);
  endtask
  task rc(input logic [13:0] i, input logic [31:0] e);
    xfer(1'h0, i, 8'h00);
    chk(r, e);
  endtask
  // status read clears what it returns
  task st(input logic [31:0] e);
    tick(2);
    rc(`DFMC_IDX_STATUS, e);
  endtask
  // one-cycle event on both lines; gated copies show one edge later
  task evt(input logic [1:0] e);
    rtc_irq_in <= 1'h1;
    transfer_busy_irq_in <= 1'h1;
    tick(1);
    rtc_irq_in <= 1'h0;
    transfer_busy_irq_in <= 1'h0;
    tick(1);
    chk({mpu_rtc_irq_out, mpu_xfer_irq_out}, e);
    tick(2);
  endtask
  task t_reset;
    rc(`DFMC_IDX_PWR_EQN, 32'h0);
    rc(`DFMC_IDX_MISC, 32'h0);
    chk(emulator_clock_enable_out, 1'h1);
    rc(`DFMC_IDX_MEEN, 32'h0);
    rc(14'h0001, 32'h0);
    chk(err, 1'h1);
  endtask
  task t_erase;
    wr(`DFMC_IDX_ERASE_CMD, 8'haa);
    st(32'h0);
    wr(`DFMC_IDX_MEEN, 8'h02);
    wr(`DFMC_IDX_ERASE_CMD, 8'h33);
    st(32'h0);
    // no emulator is attached, so the clock-off set is waited for and checked on the enable output
    wr(`DFMC_IDX_MISC, 8'h20);
    tick(1); // enable flop lands one edge after the write edge
    chk(emulator_clock_enable_out, 1'h0);
    wr(`DFMC_IDX_ERASE_CMD, 8'haa);
    st(32'h0);
    wr(`DFMC_IDX_MISC, 8'h00);
    wr(`DFMC_IDX_ERASE_CMD, 8'haa);
    st(32'h4);
    wr(`DFMC_IDX_PAGE, 8'hfe);
    wr(`DFMC_IDX_ERASE_CMD, 8'h55);
    st(32'h8);
    chk(erase_page_number_out, 7'h7f);
    wr(`DFMC_IDX_ERASE_CMD, 8'h55);
    st(32'h0);
  endtask
  task t_ports;
    wr(`DFMC_IDX_DISPLAY_PIN_COUNT, 8'h02);
    wr(`DFMC_IDX_DIR0, 8'h0f);
    wr(`DFMC_IDX_DIR2, 8'h3f);
    wr(`DFMC_IDX_PORT0, 8'h5a);
    wr(`DFMC_IDX_PORT2, 8'h3f);
    tick(4);
    chk(gp_pin_oe_out, 22'h0f000f);
    chk({gp_pin_out[21:16], gp_pin_out[7:0]}, 14'h0f0a);
    rc(`DFMC_IDX_PORT0, 32'h7a);
    rc(`DFMC_IDX_PORT2, 32'h0f);
  endtask
  task t_route;
    wr(`DFMC_IDX_DIR0, 8'hcf);
    wr(`DFMC_IDX_ROUTE, 8'h0c);
    reactive_energy_pulse_in <= 1'h1;
    tick(3);
    chk(gp_pin_out[7:6], 2'h2);
    reactive_energy_pulse_in <= 1'h0;
    real_energy_pulse_in <= 1'h1;
    tick(3);
    chk(gp_pin_out[7:6], 2'h1);
    real_energy_pulse_in <= 1'h0;
    wr(`DFMC_IDX_ROUTE, 8'h10);
    wr(`DFMC_IDX_EE_CTL, 8'h03);
    tick(4);
    chk({gp_pin_oe_out[5:4], gp_pin_out[5:4]}, 4'hd);
    rc(`DFMC_IDX_EE_CTL, 32'h03);
    wr(`DFMC_IDX_EE_CTL, 8'h01);
    tick(4);
    xfer(1'h0, `DFMC_IDX_EE_CTL, 8'h00);
    chk(r[7], 1'h1);
  endtask
  task t_irq;
    wr(`DFMC_IDX_IRQ_EN, 8'h02);
    wr(`DFMC_IDX_MASK, 8'h03);
    evt(2'h2);
    chk(irq_out, 1'h1);
    st(32'h2);
    tick(2);
    chk(irq_out, 1'h0);
    wr(`DFMC_IDX_MASK, 8'h00);
    wr(`DFMC_IDX_IRQ_EN, 8'h03);
    evt(2'h3);
    chk(irq_out, 1'h0);
    st(32'h3);
  endtask
  task t_cfg;
    for (int k = 0; k < 8; k++) begin
      wr(`DFMC_IDX_PWR_EQN, {k[2:0], 5'h00});
      rc(`DFMC_IDX_PWR_EQN, {24'h0, k[2:0], 5'h00});
      chk(power_equation_out, k[2:0]);
    end
    wr(`DFMC_IDX_MISC, 8'h12);
    rc(`DFMC_IDX_MISC, 32'h12);
    chk({decimation_long_out, supply_current_reduce_out}, 2'h3);
  endtask
  // reset held four edges, then every scenario in turn
  initial begin
    {rst_in, psel_in, penable_in, pwrite_in} = 4'h8;
    {paddr_in, pwdata_in} = 48'h0;
    {reactive_energy_pulse_in, real_energy_pulse_in} = 2'h0;
    {transfer_busy_irq_in, rtc_irq_in} = 2'h0;
    ext = 22'h3fff70;
    num_errors = 0;
    checks = 0;
    tick(4);
    rst_in <= 1'h0;
    tick(1);
    t_reset;
    t_erase;
    t_ports;
    t_route;
    t_irq;
    t_cfg;
    finish_test;
  end
endmodule
